// [msa_defines.svh]
// constants for the measurement start-arming block
`ifndef MSA_DEFINES_SVH
`define MSA_DEFINES_SVH

`define MSA_CNT_W         24
`define MSA_ADDR_W        8
`define MSA_DATA_W        32
`define MSA_WIDTH_W       32

`define MSA_OFS_CTRL      8'h00
`define MSA_OFS_TDLY      8'h04
`define MSA_OFS_EDLY      8'h08
`define MSA_OFS_MTIME     8'h0C
`define MSA_OFS_STATUS    8'h10
`define MSA_OFS_WIDTH     8'h14

`define MSA_CTRL_W        7
`define MSA_ST_ARMED_BIT  3
`define MSA_ST_GATE_BIT   4

`define MSA_RST_CTRL      7'h00
`define MSA_RST_TDLY      24'h00_0002
`define MSA_RST_EDLY      24'h00_0002
`define MSA_RST_MTIME     24'h00_0000

`define MSA_CLK_PERIOD_NS 40
`define MSA_STEP_NS       100
`define MSA_TICK_INC      4'(`MSA_CLK_PERIOD_NS / 20)
`define MSA_TICK_MOD      4'(`MSA_STEP_NS / 20)
`define MSA_TDLY_MIN_NS   200
`define MSA_TDLY_MIN      24'(`MSA_TDLY_MIN_NS / `MSA_STEP_NS)
`define MSA_EDLY_MIN      24'h00_0002
`define MSA_IDLE_MIN_NS   3000000
`define MSA_IDLE_MIN      24'(`MSA_IDLE_MIN_NS / `MSA_STEP_NS)

`endif

// [msa_pkg.sv]
// types shared by the start-arming block
`default_nettype none
package msa_pkg;
	`include "msa_defines.svh"

	typedef enum logic [1:0] {
		MSA_ARM_OFF   = 2'h0,
		MSA_ARM_NODLY = 2'h1,
		MSA_ARM_TIME  = 2'h2,
		MSA_ARM_EVENT = 2'h3
	} msa_mode_type;

	typedef struct packed {
		logic         route;
		logic         meas_neg;
		logic         arm_trail;
		logic         arm_aux;
		msa_mode_type mode;
		logic         enable;
	} msa_cfg_type;

	typedef struct packed {
		logic arm_in;
		logic aux_in;
		logic meas_in;
	} msa_sig_type;

	typedef enum logic [2:0] {
		MSA_ST_OFF   = 3'h0,
		MSA_ST_WAIT  = 3'h1,
		MSA_ST_DELAY = 3'h3,
		MSA_ST_ARMED = 3'h2,
		MSA_ST_GATE  = 3'h6,
		MSA_ST_PACE  = 3'h7
	} msa_state_type;
endpackage
`default_nettype wire

// [msa_down_counter.sv]
// loadable down counter for arming delay and measurement pacing
`default_nettype none
module msa_down_counter #(
	parameter int W = 24
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         dec,
	output logic              zero
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = load_val;
		end else if (dec && cnt_q != '0) begin
			cnt_d = cnt_q - W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end

	assign zero = (cnt_q == '0);
endmodule
`default_nettype wire

// [msa_measurement_start_arming.sv]
// start-arming, gating and pacing logic with its apb register file
//
// The APB slave port and the address map are this design's own decisions.
`default_nettype none
`include "msa_defines.svh"

module msa_measurement_start_arming
	import msa_pkg::*;
(
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     ce,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`MSA_ADDR_W-1:0]   paddr,
	input  wire logic [`MSA_DATA_W-1:0]   pwdata,
	output logic      [`MSA_DATA_W-1:0]   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire msa_pkg::msa_sig_type     sig_in,
	output logic                          gate_mon,
	output logic                          armed
);
	import msa_pkg::*;

	function automatic logic [`MSA_CNT_W-1:0] at_least(
		input logic [`MSA_CNT_W-1:0] v,
		input logic [`MSA_CNT_W-1:0] m
	);
		at_least = (v < m) ? m : v;
	endfunction

	function automatic logic edge_of(
		input logic prev,
		input logic cur,
		input logic falling
	);
		edge_of = falling ? (prev && !cur) : (!prev && cur);
	endfunction

	function automatic logic is_mapped(
		input logic [`MSA_ADDR_W-1:0] a
	);
		case (a)
			`MSA_OFS_CTRL, `MSA_OFS_TDLY, `MSA_OFS_EDLY,
			`MSA_OFS_MTIME, `MSA_OFS_STATUS, `MSA_OFS_WIDTH: begin
				is_mapped = 1'b1;
			end
			default: begin
				is_mapped = 1'b0;
			end
		endcase
	endfunction

	// registers
	msa_cfg_type             cfg_q, cfg_d;
	logic [`MSA_CNT_W-1:0]   tdly_q, tdly_d;
	logic [`MSA_CNT_W-1:0]   edly_q, edly_d;
	logic [`MSA_CNT_W-1:0]   mtime_q, mtime_d;
	logic [`MSA_DATA_W-1:0]  prdata_q, prdata_d;
	logic                    pready_q, pready_d;
	logic                    pslverr_q, pslverr_d;

	// measurement control
	msa_state_type           state_q, state_d;
	msa_sig_type             prev_q;
	logic [3:0]              acc_q, acc_d;
	logic [`MSA_WIDTH_W-1:0] width_q, width_d;
	logic                    gate_q, gate_d;
	logic                    armed_q, armed_d;

	logic [3:0]              acc_sum;
	logic                    tick;
	logic                    aux_now, aux_prev;
	logic                    arm_now, arm_prev;
	logic                    arm_edge, aux_evt;
	logic                    start_edge, stop_edge;
	logic                    cnt_load, cnt_dec, cnt_zero;
	logic [`MSA_CNT_W-1:0]   cnt_val;
	logic                    hit, wr, mapped;

	// fractional step timebase: 100 ns is 2.5 clocks
	// the first step after a load may run short by one tick
	always_comb begin
		acc_sum = acc_q + `MSA_TICK_INC;
		tick    = (acc_sum >= `MSA_TICK_MOD);
		acc_d   = tick ? acc_sum - `MSA_TICK_MOD : acc_sum;
	end

	// input routing and edge detection
	always_comb begin
		aux_now  = cfg_q.route ? sig_in.meas_in : sig_in.aux_in;
		aux_prev = cfg_q.route ? prev_q.meas_in : prev_q.aux_in;
		arm_now  = cfg_q.arm_aux ? aux_now : sig_in.arm_in;
		arm_prev = cfg_q.arm_aux ? aux_prev : prev_q.arm_in;
		arm_edge = edge_of(arm_prev, arm_now, cfg_q.arm_trail);
		aux_evt  = edge_of(aux_prev, aux_now,
			cfg_q.route && cfg_q.meas_neg);
		start_edge = edge_of(prev_q.meas_in, sig_in.meas_in,
			cfg_q.meas_neg);
		stop_edge  = edge_of(prev_q.meas_in, sig_in.meas_in,
			!cfg_q.meas_neg);
	end

	// arming state machine
	always_comb begin
		state_d  = state_q;
		cnt_load = 1'b0;
		cnt_val  = '0;
		cnt_dec  = 1'b0;
		width_d  = width_q;
		case (state_q)
			MSA_ST_OFF: begin
				if (cfg_q.mode == MSA_ARM_OFF) begin
					state_d = MSA_ST_ARMED;
				end else begin
					state_d = MSA_ST_WAIT;
				end
			end
			MSA_ST_WAIT: begin
				// only edges seen here count, earlier ones are dropped
				if (arm_edge) begin
					case (cfg_q.mode)
						MSA_ARM_TIME: begin
							cnt_load = 1'b1;
							cnt_val  = at_least(tdly_q, `MSA_TDLY_MIN);
							state_d  = MSA_ST_DELAY;
						end
						MSA_ARM_EVENT: begin
							cnt_load = 1'b1;
							cnt_val  = at_least(edly_q, `MSA_EDLY_MIN);
							state_d  = MSA_ST_DELAY;
						end
						default: begin
							// no delay: armed at the selected edge
							state_d = MSA_ST_ARMED;
						end
					endcase
				end
			end
			MSA_ST_DELAY: begin
				if (cfg_q.mode == MSA_ARM_EVENT) begin
					cnt_dec = aux_evt;
				end else begin
					cnt_dec = tick;
				end
				if (cnt_zero) begin
					state_d = MSA_ST_ARMED;
				end
			end
			MSA_ST_ARMED: begin
				if (start_edge) begin
					state_d = MSA_ST_GATE;
					// width restarts with each gate
					width_d = '0;
				end
			end
			MSA_ST_GATE: begin
				// the preset time plays no part in the interval itself
				// saturates instead of wrapping
				if (width_q != '1) begin
					width_d = width_q + `MSA_WIDTH_W'(1);
				end
				if (stop_edge) begin
					cnt_load = 1'b1;
					cnt_val  = at_least(mtime_q, `MSA_IDLE_MIN);
					state_d  = MSA_ST_PACE;
				end
			end
			MSA_ST_PACE: begin
				cnt_dec = tick;
				if (cnt_zero) begin
					if (cfg_q.mode == MSA_ARM_OFF) begin
						state_d = MSA_ST_ARMED;
					end else begin
						state_d = MSA_ST_WAIT;
					end
				end
			end
			default: begin
				state_d = MSA_ST_OFF;
			end
		endcase
		// disabling wins over any pending arm or gate
		if (!cfg_q.enable) begin
			state_d  = MSA_ST_OFF;
			cnt_load = 1'b0;
			cnt_dec  = 1'b0;
		end
		// decoded from state_d so each flop tracks state_q
		gate_d  = (state_d == MSA_ST_GATE);
		armed_d = (state_d == MSA_ST_ARMED);
	end

	// one counter serves delay and pacing, which never overlap
	msa_down_counter #(
		.W(`MSA_CNT_W)
	) u_cnt (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.load     (cnt_load),
		.load_val (cnt_val),
		.dec      (cnt_dec),
		.zero     (cnt_zero)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= MSA_ST_OFF;
			prev_q  <= '0;
			acc_q   <= '0;
			width_q <= '0;
			gate_q  <= 1'b0;
			armed_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			prev_q  <= sig_in;
			acc_q   <= acc_d;
			width_q <= width_d;
			gate_q  <= gate_d;
			armed_q <= armed_d;
		end
	end

	// apb slave: one wait state, so read data comes out of a register
	always_comb begin
		hit    = psel && penable;
		wr     = hit && pready_q && pwrite;
		mapped = is_mapped(paddr);
		pready_d  = hit && !pready_q;
		pslverr_d = hit && !pready_q && !mapped;
		prdata_d  = '0;
		if (hit && !pready_q && !pwrite) begin
			case (paddr)
				`MSA_OFS_CTRL:   prdata_d = `MSA_DATA_W'(cfg_q);
				`MSA_OFS_TDLY:   prdata_d = `MSA_DATA_W'(tdly_q);
				`MSA_OFS_EDLY:   prdata_d = `MSA_DATA_W'(edly_q);
				`MSA_OFS_MTIME:  prdata_d = `MSA_DATA_W'(mtime_q);
				`MSA_OFS_STATUS: prdata_d = `MSA_DATA_W'({gate_q, armed_q,
					state_q});
				`MSA_OFS_WIDTH:  prdata_d = width_q;
				default:         prdata_d = '0;
			endcase
		end
		cfg_d   = cfg_q;
		tdly_d  = tdly_q;
		edly_d  = edly_q;
		mtime_d = mtime_q;
		if (wr) begin
			case (paddr)
				`MSA_OFS_CTRL:  cfg_d   = msa_cfg_type'(
					pwdata[`MSA_CTRL_W-1:0]);
				`MSA_OFS_TDLY:  tdly_d  = pwdata[`MSA_CNT_W-1:0];
				`MSA_OFS_EDLY:  edly_d  = pwdata[`MSA_CNT_W-1:0];
				`MSA_OFS_MTIME: mtime_d = pwdata[`MSA_CNT_W-1:0];
				default: begin
					// status and width are read only
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q     <= msa_cfg_type'(`MSA_RST_CTRL);
			tdly_q    <= `MSA_RST_TDLY;
			edly_q    <= `MSA_RST_EDLY;
			mtime_q   <= `MSA_RST_MTIME;
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			cfg_q     <= cfg_d;
			tdly_q    <= tdly_d;
			edly_q    <= edly_d;
			mtime_q   <= mtime_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata   = prdata_q;
	assign pready   = pready_q;
	assign pslverr  = pslverr_q;
	assign gate_mon = gate_q;
	assign armed    = armed_q;
endmodule
`default_nettype wire

// [msa_monitor.sv]
// assertion checker for the start-arming block
`default_nettype none
module msa_monitor (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire msa_pkg::msa_sig_type sig_in,
	input wire logic                 gate_mon,
	input wire logic                 armed
);
	timeunit 1ns;
	timeprecision 1ns;
	import msa_pkg::*;
	logic m;
	assign m = sig_in.meas_in;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_gate_arm; $rose(gate_mon) |-> $past(armed); endproperty
	property p_excl; gate_mon |-> !armed; endproperty
	property p_pace; $fell(gate_mon) |=> !armed [*8]; endproperty
	property p_start; $rose(gate_mon) |-> $past(m) != $past(m, 2); endproperty
	property p_stop; $fell(gate_mon) |-> $past(m) != $past(m, 2); endproperty
	property p_hold; gate_mon && $stable(m) |=> gate_mon; endproperty
	// write traffic may disable, so only quiet bus cycles count
	property p_wait;
		armed && $stable(m) && !psel && !$past(psel) |=> armed;
	endproperty
	property p_rdy; psel && penable && !pready |=> pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	a_gate_arm: assert property (p_gate_arm)
		else $error("gate opened while not armed");
	a_excl: assert property (p_excl)
		else $error("armed still high with gate open");
	a_pace: assert property (p_pace)
		else $error("armed again right after gate");
	a_start: assert property (p_start)
		else $error("gate opened without a start edge");
	a_stop: assert property (p_stop)
		else $error("gate closed without a stop edge");
	a_hold: assert property (p_hold)
		else $error("gate cut short");
	a_wait: assert property (p_wait)
		else $error("armed dropped without start edge");
	a_rdy: assert property (p_rdy)
		else $error("no ready in access cycle");
	a_err: assert property (p_err)
		else $error("error without ready");
	c_gate: cover property ($rose(gate_mon));
	c_arm: cover property ($rose(armed));
	c_err: cover property (pslverr);
endmodule
bind msa_measurement_start_arming msa_monitor msa_monitor_i (
	.pclk, .presetn, .psel, .penable, .pready, .pslverr, .sig_in,
	.gate_mon, .armed);
`default_nettype wire

// [msa_source.sv]
// sync and burst source on the far side
`default_nettype none
module msa_source (
	input  wire logic            pclk,
	input  wire logic            go,
	input  wire logic            neg,
	output msa_pkg::msa_sig_type sig,
	output logic [3:0]           idx
);
	timeunit 1ns;
	timeprecision 1ns;
	import msa_pkg::*;
	logic [5:0] c = 6'h00;
	logic       a;
	logic       m;
	always @(posedge pclk)
		c <= go ? 6'h01 : (c != 6'h00 && c < 6'h30) ? c + 6'h01 : 6'h00;
	// sync leads pulse 1 by three cycles, falls in the same cycle as it
	assign a = c >= 6'h01 && c <= 6'h05;
	assign m = c >= 6'h04 && c < 6'h2C && (c - 6'h04) % 6'h05 < 6'h02;
	assign sig = '{arm_in: a, aux_in: m, meas_in: m ^ neg};
	assign idx = 4'((c + 6'h01) / 6'h05);
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the start-arming block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import msa_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        gate_mon;
	logic        armed;
	logic        go = 1'b0;
	logic        ce = 1'b1;
	logic        neg = 1'b0;
	logic [3:0]  idx;
	msa_sig_type sig;
	int          bad_count = 0;
	int          check_count = 0;
	logic [32:0] rq[$];
	logic [3:0]  gq[$];
	// ctrl, tdly, edly, slope, pulse index that opens the gate
	logic [31:0] t[9] = '{32'h0102_0201, 32'h0302_0201, 32'h1302_0202,
		32'h2302_0211, 32'h6B02_0212, 32'h0506_0204, 32'h0702_0103,
		32'h0702_0304, 32'h4702_0304};
	initial forever #20 pclk = ~pclk;
	msa_measurement_start_arming msa_measurement_start_arming_i (
		.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sig_in(sig), .gate_mon,
		.armed);
	msa_source msa_source_i (.pclk, .go, .neg, .sig, .idx);
	task automatic chk(string n, logic [32:0] e, logic [32:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic burst(logic [3:0] e);
		if (e != 4'h0)
			gq.push_back(e);
		@(posedge pclk) go <= 1'b1;
		@(posedge pclk) go <= 1'b0;
		repeat (60) @(posedge pclk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk("read", rq.pop_front(), {pslverr, prdata});
	// a gate with nothing noted is compared against zero
	// index is read once the launching edge has settled
	always @(posedge gate_mon) begin
		@(negedge pclk);
		chk("gate", gq.size() ? gq.pop_front() : 4'h0, idx);
	end
	initial begin
		repeat (90000) @(posedge pclk);
		bad_count++;
		print_verdict();
	end
	initial begin
		logic [31:0] v;
		void'($urandom(80070));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 33'h0_0000_0000);
		rd(8'h04, 33'h0_0000_0002);
		rd(8'h08, 33'h0_0000_0002);
		rd(8'h10, 33'h0_0000_0000);
		rd(8'h20, 33'h1_0000_0000);
		for (int i = 0; i < 9; i++) begin
			neg <= t[i][4];
			apb(1'b1, 8'h04, {24'h00_0000, t[i][23:16]});
			apb(1'b1, 8'h08, {24'h00_0000, t[i][15:8]});
			apb(1'b1, 8'h00, {24'h00_0000, t[i][31:24]});
			repeat ($urandom_range(30, 3)) @(posedge pclk);
			chk("armed", 33'(t[i][26:25] == 2'b00), 33'(armed));
			burst(t[i][3:0]);
			apb(1'b1, 8'h00, 32'h0000_0000);
		end
		// kept below the 3 ms floor, so spacing stays at the floor
		v = $urandom() & 32'h0000_3FFF;
		apb(1'b1, 8'h0C, v);
		rd(8'h0C, {1'b0, v});
		apb(1'b1, 8'h00, 32'h0000_0003);
		burst(4'h1);
		burst(4'h0);
		// a frozen stretch must push the end of pacing out
		repeat (1000) @(posedge pclk);
		ce <= 1'b0;
		repeat (2000) @(posedge pclk);
		ce <= 1'b1;
		repeat (70000) @(posedge pclk);
		chk("armed", 33'h0_0000_0000, {32'h0000_0000, armed});
		rd(8'h10, 33'h0_0000_0007);
		repeat (3000) @(posedge pclk);
		rd(8'h10, 33'h0_0000_0007);
		repeat (3000) @(posedge pclk);
		rd(8'h10, 33'h0_0000_0001);
		burst(4'h1);
		chk("left", 33'h0_0000_0000, 33'(gq.size()));
		print_verdict();
	end
endmodule
`default_nettype wire
